// File: include/eqmc_pkg.sv
package eqmc_pkg;

    // Register offsets within one quadrant
    localparam logic [8:0] EQMC_OFS_IRQ_SRC = 9'h008;
    localparam logic [8:0] EQMC_OFS_LINK = 9'h009;
    localparam logic [8:0] EQMC_OFS_DIAG = 9'h00a;
    localparam logic [8:0] EQMC_OFS_TEST = 9'h00b;

    // Interrupt source bit positions
    localparam int EQMC_SRC_JATT = 7;
    localparam int EQMC_SRC_PARITY = 6;
    localparam int EQMC_SRC_FRAMER = 5;
    localparam int EQMC_SRC_PERF = 4;
    localparam int EQMC_SRC_ESTORE = 3;
    localparam int EQMC_SRC_HDLC_RX = 2;
    localparam int EQMC_SRC_HDLC_TX = 1;
    localparam int EQMC_SRC_CLK_REC = 0;

    // National bit count, Sa4 in the top position
    localparam int EQMC_NATBITS = 5;

    // Values after reset
    localparam logic [6:0] EQMC_LINK_RST = 7'h10;
    localparam logic [3:0] EQMC_DIAG_RST = 4'h0;
    localparam logic [7:0] EQMC_SRC_RST = 8'h00;
    localparam logic [4:0] EQMC_NONE_PENDING = 5'h00;

    // Data-link enables, laid out as bits 6..0 of the register
    typedef struct packed {
        logic natbit_change_irq_en;
        logic natbit_change_flag;
        logic [4:0] extract_en;
    } eqmc_link_t;

    // Loopback and transmit controls
    typedef struct packed {
        logic payload_loopback_en;
        logic line_loopback_en;
        logic digital_loopback_en;
        logic transmit_disable;
    } eqmc_diag_t;

    // Test controls, laid out as bits 7..0 of the register
    typedef struct packed {
        logic test_select_plain;
        logic [1:0] substitute_addr_bits;
        logic factory_test_select;
        logic bus_driver_ctrl;
        logic board_test_select;
        logic data_bus_float;
        logic io_float;
    } eqmc_test_t;

    typedef enum logic [1:0] {LK_IDLE, LK_HIGH, LK_LOW} eqmc_lk_state_t;

endpackage

// File: hdl/eqmc_quadrant_ctrl.sv
`timescale 1ns/10ps
module eqmc_quadrant_ctrl
    import eqmc_pkg::*;
#(
    parameter logic [8:0] QUAD_BASE = 9'h000
) (
    // Clock and resets
    input wire logic clk,
    input wire logic rst_n,
    input wire logic quad_soft_reset,
    // Microprocessor pins
    input wire logic chip_select_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [8:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // Interrupt sources and pin
    input wire logic [7:0] block_irq,
    output logic irq_out_n,
    // National bits from the framer
    input wire logic natbit_valid,
    input wire logic [4:0] natbits,
    input wire logic ts16_strobe,
    input wire logic ts16_data,
    // Link routing controls and sources
    input wire logic link_internal_term_sel,
    input wire logic fractional_out_en,
    input wire logic frac_data,
    input wire logic frac_clock,
    input wire logic rx_link_irq_out,
    input wire logic rx_link_end_of_msg,
    output logic rx_link_data_out,
    output logic rx_link_clock_out,
    output logic hdlc_rx_data,
    output logic hdlc_rx_strobe,
    // Loopback data paths
    input wire logic es_data,
    input wire logic bp_tx_data,
    output logic tran_in,
    output logic backplane_rx_data,
    input wire logic cr_pos,
    input wire logic cr_neg,
    input wire logic tx_pos,
    input wire logic tx_neg,
    output logic jatt_in_pos,
    output logic jatt_in_neg,
    input wire logic jatt_out_pos,
    input wire logic jatt_out_neg,
    input wire logic line_pos,
    input wire logic line_neg,
    output logic rx_in_pos,
    output logic rx_in_neg,
    input wire logic tran_data,
    output logic tran_out,
    // Test controls
    output logic block_test_mode,
    output logic io_float
);

    function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
        hit = (a == (QUAD_BASE | ofs));
    endfunction

    // Lowest-numbered pending position is Sa4 (bit 4), so the highest pending bit wins
    function automatic logic [4:0] first_pending(input logic [4:0] p);
        first_pending = 5'h00;
        for (int i = 0; i < EQMC_NATBITS; i++) begin
            if (p[i]) begin
                first_pending = 5'h00;
                first_pending[i] = 1'b1;
            end
        end
    endfunction

    // Pin synchronisers
    logic cs_n_m, cs_n_s, cs_n_d;
    logic rd_n_m, rd_n_s, rd_n_d;
    logic wr_n_m, wr_n_s, wr_n_d;
    logic [8:0] addr_m, addr_s;
    logic [7:0] din_m, din_s;

    always_ff @(posedge clk) begin
        cs_n_m <= chip_select_n;
        cs_n_s <= cs_n_m;
        cs_n_d <= cs_n_s;
        rd_n_m <= rd_n;
        rd_n_s <= rd_n_m;
        rd_n_d <= rd_n_s;
        wr_n_m <= wr_n;
        wr_n_s <= wr_n_m;
        wr_n_d <= wr_n_s;
        addr_m <= addr;
        addr_s <= addr_m;
        din_m <= data_in;
        din_s <= din_m;
    end

    eqmc_link_t link;
    eqmc_diag_t diag;
    eqmc_test_t test;
    logic [7:0] src_q;
    logic [4:0] prev_nat;
    logic nat_seen;

    wire logic [8:0] eff_addr = test.factory_test_select ?
        {test.substitute_addr_bits, addr_s[6:0]} : addr_s;
    wire logic wr_evt = wr_n_s && !wr_n_d && !cs_n_d;
    wire logic rd_active = !rd_n_s && !cs_n_s;
    wire logic rd_end = rd_n_s && !rd_n_d && !cs_n_d;
    wire logic wr_link = wr_evt && hit(eff_addr, EQMC_OFS_LINK);
    wire logic wr_diag = wr_evt && hit(eff_addr, EQMC_OFS_DIAG);
    wire logic wr_test = wr_evt && hit(eff_addr, EQMC_OFS_TEST);
    wire logic rd_link_end = rd_end && hit(eff_addr, EQMC_OFS_LINK);
    wire logic soft_clr = !rst_n || quad_soft_reset;

    // National change detect on bits that are not extracted
    wire logic [4:0] nat_diff = (natbits ^ prev_nat) & ~link.extract_en;
    wire logic nat_change = natbit_valid && nat_seen && (|nat_diff);
    wire logic next_flag = nat_change ? 1'b1 :
        (rd_link_end ? 1'b0 : link.natbit_change_flag);

    // Interrupt sources; combined framer bit
    wire logic nat_irq = link.natbit_change_flag
        && link.natbit_change_irq_en;
    logic [7:0] next_src;
    always_comb begin
        next_src = block_irq;
        next_src[EQMC_SRC_FRAMER] = block_irq[EQMC_SRC_FRAMER]
            || nat_irq;
    end

    always_ff @(posedge clk) begin
        if (soft_clr) begin
            link <= EQMC_LINK_RST;
            diag <= EQMC_DIAG_RST;
            prev_nat <= EQMC_NONE_PENDING;
            nat_seen <= 1'b0;
        end else begin
            if (wr_link) begin
                link.natbit_change_irq_en <= din_s[6];
                link.extract_en <= din_s[4:0];
            end
            link.natbit_change_flag <= next_flag;
            if (wr_diag) begin
                diag <= {din_s[5], din_s[4], din_s[2], din_s[0]};
            end
            if (natbit_valid) begin
                prev_nat <= natbits;
                nat_seen <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            src_q <= EQMC_SRC_RST;
            irq_out_n <= 1'b1;
        end else begin
            src_q <= next_src;
            irq_out_n <= !(|next_src);
        end
    end

    // Test register: hard reset only, address bits kept, factory select cleared while chip select is high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            test.test_select_plain <= 1'b0;
            test.bus_driver_ctrl <= 1'b0;
            test.board_test_select <= 1'b0;
            test.data_bus_float <= 1'b0;
            test.io_float <= 1'b0;
        end else if (wr_test) begin
            test.test_select_plain <= din_s[7];
            test.bus_driver_ctrl <= din_s[3];
            test.board_test_select <= din_s[2];
            test.data_bus_float <= din_s[1];
            test.io_float <= din_s[0];
        end
        if (wr_test) begin
            test.substitute_addr_bits <= din_s[6:5];
        end
        if (cs_n_s) begin
            test.factory_test_select <= 1'b0;
        end else if (wr_test) begin
            test.factory_test_select <= din_s[4];
        end
    end

    // Register read and data bus drive
    wire logic [7:0] rd_mux =
        hit(eff_addr, EQMC_OFS_IRQ_SRC) ? src_q :
        hit(eff_addr, EQMC_OFS_LINK) ? {1'b0, link} :
        hit(eff_addr, EQMC_OFS_DIAG) ? {2'b00, diag.payload_loopback_en,
            diag.line_loopback_en, 1'b0, diag.digital_loopback_en, 1'b0,
            diag.transmit_disable} :
        hit(eff_addr, EQMC_OFS_TEST) ? {1'b0, test.substitute_addr_bits,
            2'b00, test.board_test_select, 1'b0, test.io_float} : 8'h00;
    wire logic any_test = test.board_test_select
        || test.factory_test_select;
    wire logic bus_by_cs = test.bus_driver_ctrl && any_test;
    wire logic next_oe = bus_by_cs ? cs_n_s
        : (rd_active && !test.data_bus_float);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
            block_test_mode <= 1'b0;
            io_float <= 1'b0;
        end else begin
            data_out <= rd_mux;
            data_oe <= next_oe;
            block_test_mode <= any_test || test.test_select_plain;
            io_float <= test.io_float;
        end
    end

    // Data-link serialiser: one clock pulse per enabled national bit
    eqmc_lk_state_t lk_state;
    logic [4:0] pend;
    logic [4:0] sa_cap;
    wire logic [4:0] cur = first_pending(pend);
    wire logic ts16_mode = (link.extract_en == EQMC_NONE_PENDING);

    always_ff @(posedge clk) begin
        if (soft_clr) begin
            lk_state <= LK_IDLE;
            pend <= EQMC_NONE_PENDING;
            sa_cap <= EQMC_NONE_PENDING;
        end else begin
            unique case (lk_state)
                LK_IDLE: begin
                    if (natbit_valid && !ts16_mode) begin
                        pend <= link.extract_en;
                        sa_cap <= natbits;
                        lk_state <= LK_HIGH;
                    end
                end
                LK_HIGH: begin
                    lk_state <= LK_LOW;
                end
                LK_LOW: begin
                    pend <= pend & ~cur;
                    lk_state <= ((pend & ~cur) != EQMC_NONE_PENDING) ?
                        LK_HIGH : LK_IDLE;
                end
                default: begin
                    lk_state <= LK_IDLE;
                end
            endcase
        end
    end

    wire logic lk_bit = ts16_mode ? ts16_data : (|(sa_cap & cur));
    wire logic lk_pulse = ts16_mode ? ts16_strobe
        : (lk_state == LK_HIGH);

    // Shared pin routing: fractional, then termination, then raw link
    wire logic pin_data = fractional_out_en ? frac_data :
        link_internal_term_sel ? rx_link_irq_out : lk_bit;
    wire logic pin_clk = fractional_out_en ? frac_clock :
        link_internal_term_sel ? rx_link_end_of_msg : lk_pulse;

    always_ff @(posedge clk) begin
        if (soft_clr) begin
            rx_link_data_out <= 1'b0;
            rx_link_clock_out <= 1'b0;
            hdlc_rx_data <= 1'b0;
            hdlc_rx_strobe <= 1'b0;
        end else begin
            rx_link_data_out <= pin_data;
            rx_link_clock_out <= pin_clk;
            hdlc_rx_data <= lk_bit;
            hdlc_rx_strobe <= lk_pulse && link_internal_term_sel;
        end
    end

    // Loopback and transmit data paths
    always_ff @(posedge clk) begin
        if (soft_clr) begin
            tran_in <= 1'b0;
            backplane_rx_data <= 1'b1;
            jatt_in_pos <= 1'b0;
            jatt_in_neg <= 1'b0;
            rx_in_pos <= 1'b0;
            rx_in_neg <= 1'b0;
            tran_out <= 1'b0;
        end else begin
            tran_in <= diag.payload_loopback_en ? es_data : bp_tx_data;
            backplane_rx_data <= diag.payload_loopback_en
                || es_data;
            jatt_in_pos <= diag.line_loopback_en ? cr_pos : tx_pos;
            jatt_in_neg <= diag.line_loopback_en ? cr_neg : tx_neg;
            rx_in_pos <= diag.digital_loopback_en ?
                jatt_out_pos : line_pos;
            rx_in_neg <= diag.digital_loopback_en ? jatt_out_neg : line_neg;
            tran_out <= tran_data && !diag.transmit_disable;
        end
    end

    // Checks
    AST_IRQ_PIN: assert property (
        @(posedge clk) disable iff (!rst_n) irq_out_n == !(|src_q))
        else $error("interrupt pin disagrees with sources");
    AST_SRC_COMBINED: assert property (
        @(posedge clk) disable iff (!rst_n)
        (nat_irq && !quad_soft_reset) |=> src_q[EQMC_SRC_FRAMER])
        else $error("combined framer source bit not set");
    AST_FLAG_SET: assert property (
        @(posedge clk) disable iff (soft_clr)
        nat_change |=> link.natbit_change_flag)
        else $error("national change flag not set");
    AST_FLAG_CLEAR: assert property (
        @(posedge clk) disable iff (soft_clr)
        (rd_link_end && !nat_change) |=> !link.natbit_change_flag)
        else $error("national change flag not cleared by read");
    AST_LINK_RESET: assert property (
        @(posedge clk) !rst_n |=> link == EQMC_LINK_RST)
        else $error("link register reset value wrong");
    AST_DIAG_RESET: assert property (
        @(posedge clk) !rst_n |=> diag == EQMC_DIAG_RST)
        else $error("loopback selects not cleared");
    AST_TRANSMIT_DISABLE: assert property (
        @(posedge clk) disable iff (soft_clr)
        diag.transmit_disable |=> !tran_out)
        else $error("transmit output not forced to zero");
    AST_PAYLOAD: assert property (
        @(posedge clk) disable iff (soft_clr)
        diag.payload_loopback_en |=>
            backplane_rx_data && tran_in == $past(es_data))
        else $error("payload loopback path wrong");
    AST_TS16: assert property (
        @(posedge clk) disable iff (soft_clr)
        (ts16_mode && !fractional_out_en && !link_internal_term_sel
            && ts16_strobe) |=>
            rx_link_clock_out && rx_link_data_out == $past(ts16_data))
        else $error("timeslot 16 link not presented");
    AST_FRAC: assert property (
        @(posedge clk) disable iff (soft_clr)
        fractional_out_en |=> rx_link_data_out == $past(frac_data)
            && rx_link_clock_out == $past(frac_clock))
        else $error("fractional outputs lost priority");
    AST_DBUS: assert property (
        @(posedge clk) disable iff (!rst_n)
        (bus_by_cs && cs_n_s) |=> data_oe)
        else $error("data bus not driven with chip select high");
    AST_LINK_PULSE: assert property (
        @(posedge clk) disable iff (soft_clr)
        (lk_state == LK_HIGH) |=> lk_state == LK_LOW ##1
            (lk_state == LK_HIGH || lk_state == LK_IDLE))
        else $error("link clock pulse sequence broken");

endmodule

// File: bench/eqmc_host_model.sv
`timescale 1ns/10ps
module eqmc_host_model (
    // Clock
    input wire logic clk,
    // Bus pins driven by the host
    output logic chip_select_n,
    output logic rd_n,
    output logic wr_n,
    output logic [8:0] addr,
    output logic [7:0] data_in,
    // Bus pins driven by the device
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    initial begin
        chip_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 9'h1ff;
        data_in = 8'h00;
    end

    // Strobes held four cycles so the two sync flops see both edges
    task automatic wr(input logic [8:0] a, input logic [7:0] dv);
        @(negedge clk);
        addr = a;
        data_in = dv;
        chip_select_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
        addr = ~a;
        data_in = ~dv;
        repeat (3) @(negedge clk);
    endtask

    // Released lines show the inverse so stale values cannot pass
    task automatic rd(input logic [8:0] a, output logic [7:0] dv,
                      output logic ok);
        @(negedge clk);
        addr = a;
        chip_select_n = 1'b0;
        rd_n = 1'b0;
        ok = 1'b0;
        dv = 8'h00;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge clk);
            if (data_oe === 1'b1) begin
                ok = 1'b1;
                dv = data_out;
            end
        end
        rd_n = 1'b1;
        repeat (4) @(negedge clk);
        chip_select_n = 1'b1;
        addr = ~a;
        repeat (3) @(negedge clk);
    endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import eqmc_pkg::*;
    logic clk, rst_n, quad_soft_reset, chip_select_n, rd_n, wr_n;
    logic [8:0] addr;
    logic [7:0] data_in, data_out, block_irq, pin_cnt, hd_cnt, v, d;
    logic data_oe, irq_out_n, natbit_valid, ts16_strobe, ts16_data, ok;
    logic [4:0] natbits, pin_bits, hd_bits;
    logic link_internal_term_sel, fractional_out_en, frac_data, frac_clock;
    logic rx_link_irq_out, rx_link_end_of_msg, rx_link_data_out;
    logic rx_link_clock_out, hdlc_rx_data, hdlc_rx_strobe;
    logic es_data, bp_tx_data, tran_in, backplane_rx_data, cr_pos, cr_neg;
    logic tx_pos, tx_neg, jatt_in_pos, jatt_in_neg, jatt_out_pos;
    logic jatt_out_neg, line_pos, line_neg, rx_in_pos, rx_in_neg;
    logic tran_data, tran_out, block_test_mode, io_float;
    int fail_count = 0;
    int total_checks = 0;

    eqmc_quadrant_ctrl uut (.clk, .rst_n, .quad_soft_reset, .chip_select_n,
        .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe, .block_irq,
        .irq_out_n, .natbit_valid, .natbits, .ts16_strobe, .ts16_data,
        .link_internal_term_sel, .fractional_out_en, .frac_data, .frac_clock,
        .rx_link_irq_out, .rx_link_end_of_msg, .rx_link_data_out,
        .rx_link_clock_out, .hdlc_rx_data, .hdlc_rx_strobe, .es_data,
        .bp_tx_data, .tran_in, .backplane_rx_data, .cr_pos, .cr_neg, .tx_pos,
        .tx_neg, .jatt_in_pos, .jatt_in_neg, .jatt_out_pos, .jatt_out_neg,
        .line_pos, .line_neg, .rx_in_pos, .rx_in_neg, .tran_data, .tran_out,
        .block_test_mode, .io_float);
    eqmc_host_model host (.clk, .chip_select_n, .rd_n, .wr_n, .addr,
        .data_in, .data_out, .data_oe);

    always #12.5 clk = ~clk;

    // Link pulses seen on the shared pins and on the internal receiver
    always @(negedge clk) begin
        if (rx_link_clock_out === 1'b1) begin
            pin_cnt = pin_cnt + 8'h01;
            pin_bits = {pin_bits[3:0], rx_link_data_out};
        end
        if (hdlc_rx_strobe === 1'b1) begin
            hd_cnt = hd_cnt + 8'h01;
            hd_bits = {hd_bits[3:0], hdlc_rx_data};
        end
    end

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [8:0] a, input logic [7:0] e,
                        input logic [7:0] m, input string nm);
        logic [7:0] r;
        logic k;
        host.rd(a, r, k);
        chk(nm, e & m, k ? (r & m) : 8'hxx);
    endtask

    task automatic frame(input logic [4:0] n);
        natbits = n;
        natbit_valid = 1'b1;
        @(negedge clk);
        natbit_valid = 1'b0;
        repeat (14) @(negedge clk);
    endtask

    // Enabled bits in Sa4..Sa8 order; no enables means timeslot 16
    function automatic logic [8:0] exp_link(input logic [4:0] e,
        input logic [4:0] n, input logic [7:0] t);
        logic [3:0] c;
        logic [4:0] b;
        c = 4'h0;
        b = 5'h00;
        if (e == 5'h00)
            return {4'h8, t[4:0]};
        for (int i = 4; i >= 0; i--) begin
            if (e[i]) begin
                b = {b[3:0], n[i]};
                c = c + 4'h1;
            end
        end
        return {c, b};
    endfunction

    task automatic link_run(input logic [4:0] e, input int mode);
        logic [7:0] t;
        logic [8:0] x;
        link_internal_term_sel = (mode == 1);
        fractional_out_en = (mode == 2);
        {rx_link_irq_out, rx_link_end_of_msg, frac_data, frac_clock} =
            4'($urandom);
        host.wr(9'h009, {3'b000, e});
        t = 8'($urandom);
        pin_cnt = 8'h00;
        hd_cnt = 8'h00;
        pin_bits = 5'h00;
        hd_bits = 5'h00;
        if (e == 5'h00) begin
            for (int k = 7; k >= 0; k--) begin
                ts16_data = t[k];
                ts16_strobe = 1'b1;
                @(negedge clk);
                ts16_strobe = 1'b0;
                @(negedge clk);
            end
            repeat (4) @(negedge clk);
        end else
            frame(5'($urandom));
        x = exp_link(e, natbits, t);
        if (mode == 0) begin
            chk("link_clocks", 8'(x[8:5]), pin_cnt);
            chk("link_bits", 8'(x[4:0]), 8'(pin_bits));
        end else if (mode == 1) begin
            chk("hdlc_strobes", 8'(x[8:5]), hd_cnt);
            chk("hdlc_bits", 8'(x[4:0]), 8'(hd_bits));
            chk("term_pins", 8'({rx_link_irq_out, rx_link_end_of_msg}),
                8'({rx_link_data_out, rx_link_clock_out}));
        end else
            chk("frac_pins", 8'({frac_data, frac_clock}),
                8'({rx_link_data_out, rx_link_clock_out}));
    endtask

    initial begin
        #1ms;
        fail_count++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        quad_soft_reset = 1'b0;
        block_irq = 8'h00;
        {natbit_valid, natbits, ts16_strobe, ts16_data} = 8'h00;
        {link_internal_term_sel, fractional_out_en, frac_data} = 3'h0;
        {frac_clock, rx_link_irq_out, rx_link_end_of_msg} = 3'h0;
        {es_data, bp_tx_data, cr_pos, cr_neg, tx_pos, tx_neg, jatt_out_pos,
            jatt_out_neg, line_pos, line_neg, tran_data} = 11'h000;
        void'($urandom(32'h76f9));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rchk(9'h009, 8'h10, 8'h7f, "link_reset");
        rchk(9'h00a, 8'h00, 8'h35, "diag_reset");
        rchk(9'h00b, 8'h00, 8'h9f, "test_reset");
        for (int i = 0; i < 6; i++) begin
            block_irq = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            repeat (2) @(negedge clk);
            chk("irq_pin", 8'(block_irq == 8'h00), 8'(irq_out_n));
            rchk(9'h008, block_irq, 8'hff, "irq_source");
            rchk(9'h008, block_irq, 8'hff, "irq_source_again");
        end
        block_irq = 8'h00;
        for (int i = 0; i < 3; i++) begin
            v = 8'($urandom) & 8'hbf;
            host.wr(9'h009, v);
            rchk(9'h009, v, 8'h5f, "link_rw");
        end
        host.wr(9'h00c, 8'hff);
        rchk(9'h00c, 8'h00, 8'hff, "unmapped");
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h35 : (i == 1) ? 8'h00 : 8'($urandom);
            host.wr(9'h00a, v);
            rchk(9'h00a, v, 8'h35, "diag_rw");
            repeat (3) begin
                {es_data, bp_tx_data, cr_pos, cr_neg, tx_pos, tx_neg,
                    jatt_out_pos, jatt_out_neg, line_pos, line_neg,
                    tran_data} = 11'($urandom);
                repeat (2) @(negedge clk);
                chk("tran_in", 8'(v[5] ? es_data : bp_tx_data),
                    8'(tran_in));
                if (v[5])
                    chk("bp_rx", 8'h01, 8'(backplane_rx_data));
                chk("jatt_in", 8'(v[4] ? {cr_pos, cr_neg} : {tx_pos, tx_neg}),
                    8'({jatt_in_pos, jatt_in_neg}));
                chk("rx_in", 8'(v[2] ? {jatt_out_pos, jatt_out_neg} :
                    {line_pos, line_neg}), 8'({rx_in_pos, rx_in_neg}));
                chk("tran_out", 8'(v[0] ? 1'b0 : tran_data),
                    8'(tran_out));
            end
        end
        for (int i = 0; i < 12; i++)
            link_run((i < 3) ? 5'h00 : (i < 6) ? 5'h1f : 5'($urandom), i % 3);
        link_internal_term_sel = 1'b0;
        fractional_out_en = 1'b0;
        host.wr(9'h009, 8'h50);
        frame(5'h00);
        frame(5'h00);
        frame(5'h01);
        rchk(9'h008, 8'h20, 8'hff, "natbit_source");
        chk("natbit_irq_pin", 8'h00, 8'(irq_out_n));
        rchk(9'h009, 8'h70, 8'h7f, "change_flag_set");
        rchk(9'h009, 8'h50, 8'h7f, "change_flag_clear");
        frame(5'h11);
        rchk(9'h009, 8'h50, 8'h7f, "extracted_change");
        host.wr(9'h00a, 8'h35);
        host.wr(9'h00b, 8'h65);
        rchk(9'h00b, 8'h65, 8'h65, "test_rw");
        chk("io_float", 8'h01, 8'(io_float));
        chk("block_test", 8'h01, 8'(block_test_mode));
        quad_soft_reset = 1'b1;
        repeat (2) @(negedge clk);
        quad_soft_reset = 1'b0;
        @(negedge clk);
        rchk(9'h00b, 8'h65, 8'h65, "test_soft_kept");
        rchk(9'h009, 8'h10, 8'h7f, "link_soft");
        rchk(9'h00a, 8'h00, 8'h35, "diag_soft");
        host.wr(9'h00b, 8'h0c);
        repeat (4) @(negedge clk);
        chk("bus_drive_idle", 8'h01, 8'(data_oe));
        host.wr(9'h00b, 8'h02);
        host.rd(9'h008, d, ok);
        chk("read_floated", 8'h00, 8'(ok));
        host.wr(9'h00b, 8'h00);
        rchk(9'h00b, 8'h00, 8'hff, "test_cleared");
        complete_run();
    end
endmodule
